/* File: verilog/ssc_defines.svh */
// ssc_defines.svh: offsets, field positions, reset values and counts of
// the synthesizer serial control block.
// assumes: included by bare name from every file that needs a figure.
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// word and select codes, binary order
`define SSC_WORD_W        24
`define SSC_SEL_MSB       2
`define SSC_SEL_FREQ      3'h0
`define SSC_SEL_MODREF    3'h1
`define SSC_SEL_PHASE     3'h2
`define SSC_SEL_FUNC      3'h3
`define SSC_SEL_PUMP      3'h4
`define SSC_SEL_PWRDN     3'h5
`define SSC_SEL_MONMUX    3'h6
`define SSC_SEL_TEST      3'h7

// frequency word fields
`define SSC_INT_MSB       22
`define SSC_INT_LSB       15
`define SSC_NUM_MSB       14
`define SSC_NUM_LSB       3

// modulus/reference word fields
`define SSC_BOOST_BIT     23
`define SSC_HALF_BIT      22
`define SSC_PRESC_BIT     20
`define SSC_DBL_BIT       19
`define SSC_RCNT_MSB      18
`define SSC_RCNT_LSB      15
`define SSC_DEN_MSB       14
`define SSC_DEN_LSB       3

// phase word, pump word and monitor word fields
`define SSC_PHASE_MSB     14
`define SSC_PHASE_LSB     3
`define SSC_TMR_MSB       14
`define SSC_TMR_LSB       6
`define SSC_TSEL_MSB      5
`define SSC_TSEL_LSB      4
`define SSC_TSEL_PUMP     2'h0
`define SSC_TSEL_SW12     2'h1
`define SSC_TSEL_SW3      2'h2
`define SSC_MON_MSB       6
`define SSC_MON_LSB       3

// monitor source codes
`define SSC_MON_LOW       4'h0
`define SSC_MON_HIGH      4'h1
`define SSC_MON_FASTLOCK  4'h2
`define SSC_MON_LOCK      4'h6

// reset values
`define SSC_RST_WORD      24'h000000
`define SSC_RST_TMR       9'h000
`define SSC_RST_MON       4'h0

// timing counts
`define SSC_TMR_DIV_LAST  2'h3
`define SSC_CELL_STEPS    3'h6
`define SSC_CELLS_ALL     7'h40
`define SSC_LOCK_LAST     6'h27
`define SSC_LOCK_ERR_NS   8'h0f
`define SSC_UNLOCK_ERR_NS 8'h1e

`endif

/* File: verilog/ssc_pkg.sv */
// ssc_pkg.sv: types of the synthesizer serial control block.
// assumes: constants live in ssc_defines.svh.
`default_nettype none
package ssc_pkg;
    // fast-lock sequencer states
    typedef enum logic [1:0] {
        SSC_FL_NARROW,
        SSC_FL_WIDE,
        SSC_FL_RAMP
    } ssc_fl_state_t;

    typedef logic [23:0] ssc_word_t;
endpackage : ssc_pkg
`default_nettype wire

/* File: verilog/ssc_ctrl_mem.sv */
// ssc_ctrl_mem.sv: eight raw control words as written over the serial port.
// assumes: one write port and one read port, both on clk_i.
`timescale 1ns/100ps
`default_nettype none
module ssc_ctrl_mem #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // array itself has no reset, the device has no documented one
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // registered read data
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : ssc_ctrl_mem
`default_nettype wire

/* File: verilog/ssc_top.sv */
// ssc_top.sv: serial port, control word decode, fast-lock timers and lock
// detect of a fractional-N synthesizer.
// assumes: serial pins and the phase detector reference are asynchronous
// pins; pfd_err_ns_i is a same-clock error measurement valid at each
// phase detector rising edge.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defines.svh"

module ssc_top #(
    parameter int LOCK_CYCLES = 40
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        serial_clk_i,
    input  wire logic        serial_data_i,
    input  wire logic        load_strobe_i,
    input  wire logic        phase_detector_ref_i,
    input  wire logic [7:0]  pfd_err_ns_i,
    input  wire logic [2:0]  ctrl_rd_addr_i,
    output logic      [23:0] ctrl_rd_data_o,
    output logic      [7:0]  int_value_o,
    output logic      [11:0] numerator_word_o,
    output logic      [11:0] denominator_word_o,
    output logic      [3:0]  ref_count_o,
    output logic             ref_double_o,
    output logic             ref_half_o,
    output logic             prescaler_o,
    output logic             pump_boost_o,
    output logic      [11:0] phase_seed_o,
    output logic      [6:0]  pump_cells_o,
    output logic             filter_switch_one_o,
    output logic             filter_switch_two_o,
    output logic             filter_switch_three_o,
    output logic             fast_lock_o,
    output logic             monitor_output_o
);
    // pin synchronisers, first stage read only by the second
    logic [1:0] sclk_sync, sdat_sync, load_sync, pfd_sync;
    logic       sclk_d, load_d, pfd_d;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_sync <= 2'h0;
            sdat_sync <= 2'h0;
            load_sync <= 2'h0;
            pfd_sync  <= 2'h0;
            sclk_d    <= 1'b0;
            load_d    <= 1'b0;
            pfd_d     <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], serial_clk_i};
            sdat_sync <= {sdat_sync[0], serial_data_i};
            load_sync <= {load_sync[0], load_strobe_i};
            pfd_sync  <= {pfd_sync[0], phase_detector_ref_i};
            sclk_d    <= sclk_sync[1];
            load_d    <= load_sync[1];
            pfd_d     <= pfd_sync[1];
        end
    end

    logic sclk_rise, load_rise, pfd_rise;
    assign sclk_rise = sclk_sync[1] & ~sclk_d;
    assign load_rise = load_sync[1] & ~load_d;
    assign pfd_rise  = pfd_sync[1] & ~pfd_d;

    // input shift register, newest bit at the bottom so the first bit
    // shifted in ends up as the MSB
    ssc_pkg::ssc_word_t shift;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift <= `SSC_RST_WORD;
        end else if (sclk_rise) begin
            shift <= {shift[22:0], sdat_sync[1]};
        end
    end

    logic [2:0] sel;
    logic       we;
    assign sel = shift[`SSC_SEL_MSB:0];
    assign we  = load_rise;

    // raw words kept for readback
    ssc_ctrl_mem #(
        .WIDTH (24),
        .DEPTH (8),
        .AW    (3)
    ) u_mem (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (we),
        .waddr_i (sel),
        .wdata_i (shift),
        .raddr_i (ctrl_rd_addr_i),
        .rdata_o (ctrl_rd_data_o)
    );

    // staged words; only a load strobe edge moves anything
    ssc_pkg::ssc_word_t freq_hold, modref_shadow;
    logic [11:0] phase_shadow;
    logic [8:0]  tmr_pump, tmr_sw12, tmr_sw3;
    logic [3:0]  mon_sel;
    logic        freq_pend;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            freq_hold     <= `SSC_RST_WORD;
            modref_shadow <= `SSC_RST_WORD;
            phase_shadow  <= 12'h000;
            tmr_pump      <= `SSC_RST_TMR;
            tmr_sw12      <= `SSC_RST_TMR;
            tmr_sw3       <= `SSC_RST_TMR;
            mon_sel       <= `SSC_RST_MON;
        end else if (we) begin
            unique case (sel)
                `SSC_SEL_FREQ:   freq_hold <= shift;
                `SSC_SEL_MODREF: modref_shadow <= shift;
                `SSC_SEL_PHASE:  phase_shadow <= shift[`SSC_PHASE_MSB:`SSC_PHASE_LSB];
                `SSC_SEL_PUMP: begin
                    // timer select steers the 9-bit value to one counter, or to none for select code 3
                    if (shift[`SSC_TSEL_MSB:`SSC_TSEL_LSB] == `SSC_TSEL_PUMP)
                        tmr_pump <= shift[`SSC_TMR_MSB:`SSC_TMR_LSB];
                    if (shift[`SSC_TSEL_MSB:`SSC_TSEL_LSB] == `SSC_TSEL_SW12)
                        tmr_sw12 <= shift[`SSC_TMR_MSB:`SSC_TMR_LSB];
                    if (shift[`SSC_TSEL_MSB:`SSC_TSEL_LSB] == `SSC_TSEL_SW3)
                        tmr_sw3 <= shift[`SSC_TMR_MSB:`SSC_TMR_LSB];
                end
                `SSC_SEL_MONMUX: mon_sel <= shift[`SSC_MON_MSB:`SSC_MON_LSB];
                `SSC_SEL_FUNC, `SSC_SEL_PWRDN, `SSC_SEL_TEST: begin
                end
            endcase
        end
    end

    // frequency write waits for the next reference edge; a second write
    // before that edge simply replaces the first
    logic apply;
    assign apply = freq_pend & pfd_rise;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            freq_pend <= 1'b0;
        end else if (we && sel == `SSC_SEL_FREQ) begin
            freq_pend <= 1'b1;
        end else if (pfd_rise) begin
            freq_pend <= 1'b0;
        end
    end

    // divider and double-buffered settings take effect together
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_value_o        <= 8'h00;
            numerator_word_o   <= 12'h000;
            denominator_word_o <= 12'h000;
            ref_count_o        <= 4'h0;
            ref_double_o       <= 1'b0;
            ref_half_o         <= 1'b0;
            prescaler_o        <= 1'b0;
            pump_boost_o       <= 1'b0;
            phase_seed_o       <= 12'h000;
        end else if (apply) begin
            int_value_o        <= freq_hold[`SSC_INT_MSB:`SSC_INT_LSB];
            numerator_word_o   <= freq_hold[`SSC_NUM_MSB:`SSC_NUM_LSB];
            denominator_word_o <= modref_shadow[`SSC_DEN_MSB:`SSC_DEN_LSB];
            ref_count_o        <= modref_shadow[`SSC_RCNT_MSB:`SSC_RCNT_LSB];
            ref_double_o       <= modref_shadow[`SSC_DBL_BIT];
            ref_half_o         <= modref_shadow[`SSC_HALF_BIT];
            prescaler_o        <= modref_shadow[`SSC_PRESC_BIT];
            pump_boost_o       <= modref_shadow[`SSC_BOOST_BIT];
            phase_seed_o       <= phase_shadow;
        end
    end

    // timer clock: every fourth reference edge
    logic [1:0] tdiv;
    logic       tick;
    assign tick = pfd_rise && tdiv == `SSC_TMR_DIV_LAST;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tdiv <= 2'h0;
        end else if (pfd_rise) begin
            tdiv <= tdiv + 2'h1;
        end
    end

    // counts a timeout down to zero and holds there
    function automatic logic [8:0] ssc_count_down(input logic [8:0] c);
        ssc_count_down = (c == 9'h000) ? 9'h000 : c - 9'h001;
    endfunction : ssc_count_down

    ssc_pkg::ssc_fl_state_t fl_state;
    logic [8:0] cnt_pump, cnt_sw12, cnt_sw3;
    logic [2:0] step;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fl_state <= ssc_pkg::SSC_FL_NARROW;
            cnt_pump <= 9'h000;
            cnt_sw12 <= 9'h000;
            cnt_sw3  <= 9'h000;
            step     <= `SSC_CELL_STEPS;
        end else if (apply) begin
            fl_state <= ssc_pkg::SSC_FL_WIDE;
            cnt_pump <= tmr_pump;
            cnt_sw12 <= tmr_sw12;
            cnt_sw3  <= tmr_sw3;
            step     <= 3'h0;
        end else if (tick) begin
            cnt_sw12 <= ssc_count_down(cnt_sw12);
            cnt_sw3  <= ssc_count_down(cnt_sw3);
            unique case (fl_state)
                ssc_pkg::SSC_FL_WIDE: begin
                    cnt_pump <= ssc_count_down(cnt_pump);
                    if (cnt_pump == 9'h000)
                        fl_state <= ssc_pkg::SSC_FL_RAMP;
                end
                ssc_pkg::SSC_FL_RAMP: begin
                    step <= step + 3'h1;
                    if (step == `SSC_CELL_STEPS - 3'h1)
                        fl_state <= ssc_pkg::SSC_FL_NARROW;
                end
                ssc_pkg::SSC_FL_NARROW: begin
                end
            endcase
        end
    end

    // switch state follows the counters directly; a switch timer shorter
    // than the ramp opens early, which the host must avoid
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pump_cells_o          <= 7'h01;
            filter_switch_one_o   <= 1'b0;
            filter_switch_two_o   <= 1'b0;
            filter_switch_three_o <= 1'b0;
            fast_lock_o           <= 1'b0;
        end else begin
            pump_cells_o          <= `SSC_CELLS_ALL >> step;
            filter_switch_one_o   <= cnt_sw12 != 9'h000;
            filter_switch_two_o   <= cnt_sw12 != 9'h000;
            filter_switch_three_o <= cnt_sw3 != 9'h000;
            fast_lock_o           <= fl_state != ssc_pkg::SSC_FL_NARROW;
        end
    end

    // lock detect, evaluated once per reference cycle
    logic [5:0] good_cnt;
    logic       locked;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            good_cnt <= 6'h00;
            locked   <= 1'b0;
        end else if (apply || (pfd_rise && pfd_err_ns_i > `SSC_UNLOCK_ERR_NS)) begin
            good_cnt <= 6'h00;
            locked   <= 1'b0;
        end else if (pfd_rise) begin
            if (pfd_err_ns_i < `SSC_LOCK_ERR_NS) begin
                if (good_cnt != 6'(LOCK_CYCLES - 1))
                    good_cnt <= good_cnt + 6'h01;
                else
                    locked <= 1'b1;
            end else begin
                good_cnt <= 6'h00;
            end
        end
    end

    // monitor output mux
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            monitor_output_o <= 1'b0;
        end else begin
            unique case (mon_sel)
                `SSC_MON_HIGH:     monitor_output_o <= 1'b1;
                `SSC_MON_FASTLOCK: monitor_output_o <= fast_lock_o;
                `SSC_MON_LOCK:     monitor_output_o <= locked;
                default:           monitor_output_o <= 1'b0;
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_freq_apply;
        apply ##1 1'b1;
    endsequence

    chk_shift_in_bit: assert property (sclk_rise |=> shift[0] == $past(sdat_sync[1]))
        else $error("shift register missed serial bit");
    chk_load_only_store: assert property (!we |=> $stable(modref_shadow) && $stable(mon_sel))
        else $error("register changed without load strobe");
    chk_sel_decode_mon: assert property (we && sel == `SSC_SEL_MONMUX |=> mon_sel == $past(shift[6:3]))
        else $error("monitor select not taken from word");
    chk_freq_enter: assert property (seq_freq_apply |=> fast_lock_o && pump_cells_o == 7'h40)
        else $error("fast lock not entered on frequency apply");
    chk_apply_values: assert property (apply |=> int_value_o == $past(freq_hold[22:15]) && denominator_word_o == $past(modref_shadow[14:3]))
        else $error("divider values not applied");
    chk_tick_rate: assert property (tick |-> pfd_rise && tdiv == 2'h3)
        else $error("timer tick off the divide by four");
    chk_ramp_halve: assert property (fl_state == ssc_pkg::SSC_FL_RAMP && tick && !apply |=> ##1 pump_cells_o == ($past(pump_cells_o) >> 1))
        else $error("cell count not halved on ramp tick");
    chk_sw_open: assert property (cnt_sw3 == 9'h000 |=> !filter_switch_three_o)
        else $error("switch three closed after timeout");
    chk_lock_forty: assert property ($rose(locked) |-> $past(good_cnt) == 6'h27)
        else $error("lock rose before forty good cycles");
    chk_lock_drop: assert property (pfd_rise && pfd_err_ns_i > 8'h1e |=> !locked)
        else $error("lock held despite large error");
    chk_mon_lock: assert property (mon_sel == `SSC_MON_LOCK |=> monitor_output_o == $past(locked))
        else $error("monitor output not showing lock");
endmodule : ssc_top
`default_nettype wire

/* File: tb/ssc_host_model.sv */
// ssc_host_model.sv: host side of the three-wire serial port.
// assumes: called from the bench; pins change only on falling clk_i edges.
`timescale 1ns/100ps
`default_nettype none
module ssc_host_model (
    input  wire logic clk_i,
    output logic      serial_clk_o,
    output logic      serial_data_o,
    output logic      load_strobe_o
);
    // idle pins: clock and strobe low, data parked
    initial begin
        serial_clk_o  = 1'b0;
        serial_data_o = 1'b0;
        load_strobe_o = 1'b0;
    end

    // each level held four cycles, past the two-flop synchronizer and edge detect
    task automatic hold(input int n);
        repeat (n) @(negedge clk_i);
    endtask : hold

    // shift a whole word, msb first, data steady across each rise
    task automatic shift_word(input logic [23:0] w);
        hold(1);
        for (int i = 23; i >= 0; i--) begin
            serial_data_o = w[i];
            hold(4);
            serial_clk_o = 1'b1;
            hold(4);
            serial_clk_o = 1'b0;
        end
        serial_data_o = ~w[0]; // released line shows no stale bit
    endtask : shift_word

    // strobe rises only once all 24 bits are in
    task automatic load_word(input logic [23:0] w);
        shift_word(w);
        hold(4);
        load_strobe_o = 1'b1;
        hold(4);
        load_strobe_o = 1'b0;
        hold(4);
    endtask : load_word
endmodule : ssc_host_model
`default_nettype wire

/* File: tb/ssc_top_tb_top.sv */
// ssc_top_tb_top.sv: self-checking bench for the serial control block.
// assumes: host model drives the serial pins; bench drives reference and error.
`timescale 1ns/100ps
`default_nettype none
module ssc_top_tb_top;
    logic        clk_i  = 1'b0;
    logic        rst_i  = 1'b1;
    logic        ref_i  = 1'b0;
    logic [7:0]  err_ns = 8'h28;
    logic [2:0]  rd_addr = 3'h0;
    wire logic   sclk, sdata, sload;
    logic [23:0] rd_data;
    logic [7:0]  int_v;
    logic [11:0] num, den, seed;
    logic [3:0]  rcnt;
    logic        dbl, half, presc, boost, sw1, sw2, sw3, fl, mon;
    logic [6:0]  cells, cells_exp;
    logic [23:0] words [8];
    int          failures  = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    int          refdiv    = 0;
    int          dt;

    always #20 clk_i = ~clk_i;

    // reference at clk/16, only out of reset
    always @(negedge clk_i) begin
        if (!rst_i) begin
            refdiv <= (refdiv + 1) % 8;
            if (refdiv == 7) ref_i <= ~ref_i;
        end
    end

    ssc_host_model host (.clk_i(clk_i), .serial_clk_o(sclk), .serial_data_o(sdata),
                         .load_strobe_o(sload));

    ssc_top uut (.clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk), .serial_data_i(sdata),
        .load_strobe_i(sload), .phase_detector_ref_i(ref_i), .pfd_err_ns_i(err_ns),
        .ctrl_rd_addr_i(rd_addr), .ctrl_rd_data_o(rd_data), .int_value_o(int_v),
        .numerator_word_o(num), .denominator_word_o(den), .ref_count_o(rcnt),
        .ref_double_o(dbl), .ref_half_o(half), .prescaler_o(presc), .pump_boost_o(boost),
        .phase_seed_o(seed), .pump_cells_o(cells), .filter_switch_one_o(sw1),
        .filter_switch_two_o(sw2), .filter_switch_three_o(sw3), .fast_lock_o(fl),
        .monitor_output_o(mon));

    task automatic finish_test;
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    // readback is registered, so allow two cycles
    task automatic rd_chk(input logic [2:0] a, input logic [23:0] exp);
        rd_addr = a;
        repeat (2) @(negedge clk_i);
        check(rd_data, exp, "readback");
    endtask : rd_chk

    task automatic wait_fl(input logic v);
        int n;
        n = 0;
        while (fl !== v && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        check(24'(fl), 24'(v), "fast lock flag");
    endtask : wait_fl

    task automatic wait_change(input logic [6:0] prev, output int n);
        n = 0;
        while (cells === prev && n < 400) begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_change

    // lands mid-period, away from the reference rise
    task automatic wait_ref(input int n);
        repeat (n) @(posedge ref_i);
        repeat (8) @(negedge clk_i);
    endtask : wait_ref

    // a hang counts as a failure
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            finish_test;
        end
    end

    initial begin
        words[0] = {1'b0, 8'h64, 12'h3a5, 3'h0};
        words[1] = {1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h5, 12'h0d3, 3'h1};
        words[2] = {9'h000, 12'h5a7, 3'h2};
        words[3] = 24'h000383;
        words[4] = {9'h000, 9'h002, 2'h0, 1'b0, 3'h4};
        words[5] = 24'h000005;
        words[6] = {17'h00000, 4'h2, 3'h6};
        words[7] = 24'h000007;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        check(24'({cells, fl, sw1, sw2, sw3, mon}), 24'({7'h01, 5'h00}), "reset");
        // switch timers at pump value plus seven
        host.load_word({9'h000, 9'h009, 2'h1, 1'b0, 3'h4});
        host.load_word({9'h000, 9'h009, 2'h2, 1'b0, 3'h4});
        for (int i = 1; i < 8; i++) host.load_word(words[i]);
        check(24'(den), 24'h000000, "shadow early");
        host.shift_word(24'hffffff);
        repeat (8) @(negedge clk_i);
        for (int i = 1; i < 8; i++) rd_chk(3'(i), words[i]);
        host.load_word(words[0]);
        wait_fl(1'b1);
        repeat (2) @(negedge clk_i);
        check(24'({int_v, num}), 24'({8'h64, 12'h3a5}), "freq fields");
        check(24'({den, rcnt, dbl, half, presc, boost}), 24'({12'h0d3, 8'h5b}), "shadow");
        check(24'(seed), 24'h0005a7, "phase seed");
        check(24'({cells, sw1, sw2, sw3, mon}), 24'({7'h40, 4'hf}), "wide");
        rd_chk(3'h0, words[0]);
        cells_exp = 7'h40;
        for (int k = 0; k < 6; k++) begin
            wait_change(cells_exp, dt);
            cells_exp = cells_exp >> 1;
            check(24'(cells), 24'(cells_exp), "pump step");
            if (k > 0) check(24'(dt), 24'd64, "tick spacing");
            if (k == 4) check(24'({sw1, sw2, sw3, mon}), 24'h00000f, "ramp switches");
        end
        for (dt = 0; {fl, sw1, sw2, sw3} !== 4'h0 && dt < 400; dt++) @(negedge clk_i);
        check(24'({fl, sw1, sw2, sw3, cells}), 24'h000001, "narrow");
        host.load_word({17'h00000, 4'h1, 3'h6});
        check(24'(mon), 24'h000001, "monitor high");
        host.load_word({17'h00000, 4'h0, 3'h6});
        check(24'(mon), 24'h000000, "monitor low");
        host.load_word({17'h00000, 4'h6, 3'h6});
        // forty good cycles, boundary at the 40th
        @(negedge ref_i);
        err_ns = 8'h05;
        wait_ref(39);
        check(24'(mon), 24'h000000, "lock early");
        wait_ref(1);
        check(24'(mon), 24'h000001, "lock");
        @(negedge ref_i);
        err_ns = 8'h14;
        wait_ref(5);
        check(24'(mon), 24'h000001, "lock held");
        @(negedge ref_i);
        err_ns = 8'h1f;
        wait_ref(1);
        check(24'(mon), 24'h000000, "large error");
        @(negedge ref_i);
        err_ns = 8'h05;
        wait_ref(40);
        check(24'(mon), 24'h000001, "relock");
        host.load_word(words[0]);
        wait_fl(1'b1);
        repeat (2) @(negedge clk_i);
        check(24'(mon), 24'h000000, "new channel");
        finish_test;
    end
endmodule : ssc_top_tb_top
`default_nettype wire
